// ---- hw/ia_glue.sv ----
/*
   interrupt acknowledge glue between an 8-bit cpu bus and vectored peripherals.
   assumes cpu strobes are synchronous to clk; peripheral clock equals clk.
*/
`timescale 1ns/100ps
`default_nettype none

`include "ia_defs.svh"

module ia_glue
   import ia_pkg::*;
#(
   parameter bit          FAST_GRADE   = 1'b0,
   parameter bit          SEPARATE_CLK = 1'b0,
   parameter int unsigned EXTRA_WAIT   = `IA_EXTRA_WAIT_CYCLES
)(
   input  wire logic   clk,
   input  wire logic   rst,
   input  wire logic   opcode_fetch_cycle_n,
   input  wire logic   memory_request_n,
   input  wire logic   io_request_n,
   input  wire logic   sys_rd_n,
   input  wire logic   sys_wr_n,
   input  wire logic   sys_wait_n,
   output var  logic   cpu_wait_n,
   output var  vector_t cpu_vector,
   output var  logic   cpu_vector_valid,
   output var  logic   ack_cycle_active,
   ia_link_if.glue     link
);

   localparam int unsigned READ_NS  = FAST_GRADE ? `IA_ACK_TO_READ_FAST_NS
                                                 : `IA_ACK_TO_READ_SLOW_NS;
   localparam int unsigned VEC_NS   = FAST_GRADE ? `IA_VECTOR_VALID_FAST_NS
                                                 : `IA_VECTOR_VALID_SLOW_NS;
   localparam int unsigned READ_TAP = cycles_min(READ_NS, `IA_CLK_PERIOD_NS);
   localparam int unsigned VEC_CYC  = cycles_min(VEC_NS, `IA_CLK_PERIOD_NS);
   // margin covers the registered strobe and the vector capture stage
   localparam int unsigned WAIT_TAP = READ_TAP + VEC_CYC + `IA_STAGE_MARGIN_CYCLES
                                      + EXTRA_WAIT;
   localparam int unsigned DEPTH    = WAIT_TAP + 1;

   logic [DEPTH-1:0] stage_reg;
   logic             synced_ack_detect;
   logic             detect_now;
   logic             stage0_next;
   logic             in_ack;
   logic             read_tap;
   logic             wait_tap;

   logic             ack_n_reg;
   logic             rd_n_reg;
   logic             wr_n_reg;
   logic             legacy_ioreq_n_reg;
   logic             wait_n_reg;
   vector_t          vector_reg;
   logic             vector_valid_reg;

   logic             ack_n_next;
   logic             rd_n_next;
   logic             wr_n_next;
   logic             legacy_ioreq_n_next;
   logic             wait_n_next;

   // fetch with memory request idle can only be an acknowledge
   assign detect_now = ~opcode_fetch_cycle_n & memory_request_n;

   assign in_ack   = stage_reg[0];
   // ack leaves with stage 0 itself, so this tap gives the full read delay
   assign read_tap = stage_reg[READ_TAP-1];
   assign wait_tap = stage_reg[WAIT_TAP];

   // synchronising stage, held clear unless an acknowledge is in flight
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         synced_ack_detect <= 1'b0;
      end else if (opcode_fetch_cycle_n || !memory_request_n) begin
         synced_ack_detect <= 1'b0;
      end else begin
         synced_ack_detect <= 1'b1;
      end
   end

   // delay line; both variants count in clk, which is also the peripheral clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage_reg <= '0;
      end else if (opcode_fetch_cycle_n) begin
         stage_reg <= '0;
      end else if (SEPARATE_CLK) begin
         if (synced_ack_detect) begin
            stage_reg <= {stage_reg[DEPTH-2:0], 1'b1};
         end
      end else begin
         // memory request active feeds zeros, so fetches never advance it
         stage_reg <= {stage_reg[DEPTH-2:0], detect_now};
      end
   end

   // value stage 0 takes at this edge; ack follows it on the detect edge
   always_comb begin
      if (opcode_fetch_cycle_n) begin
         stage0_next = 1'b0;
      end else if (SEPARATE_CLK) begin
         stage0_next = synced_ack_detect | stage_reg[0];
      end else begin
         stage0_next = detect_now;
      end
   end

   // next values of the peripheral and cpu strobes
   always_comb begin
      ack_n_next = ~stage0_next;
      // read drops with ack when the cycle ends
      rd_n_next  = ~((read_tap & stage0_next) | (~sys_rd_n & ~in_ack));
      wr_n_next  = sys_wr_n;
      // ordinary io passes; acknowledge io waits for the chain to ripple
      legacy_ioreq_n_next = ~(~io_request_n & (opcode_fetch_cycle_n | read_tap));
      wait_n_next = ~((stage0_next & ~wait_tap) | ~sys_wait_n);
   end

   // reset is the peripherals' own reset: read and write both low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_n_reg          <= 1'b1;
         rd_n_reg           <= 1'b0;
         wr_n_reg           <= 1'b0;
         legacy_ioreq_n_reg <= 1'b1;
      end else begin
         ack_n_reg          <= ack_n_next;
         rd_n_reg           <= rd_n_next;
         wr_n_reg           <= wr_n_next;
         legacy_ioreq_n_reg <= legacy_ioreq_n_next;
      end
   end

   // cpu wait, held released during reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_n_reg <= 1'b1;
      end else begin
         wait_n_reg <= wait_n_next;
      end
   end

   // vector captured from the peripheral while it drives during acknowledge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vector_reg       <= `IA_VECTOR_RESET;
         vector_valid_reg <= 1'b0;
      end else if (!in_ack) begin
         vector_valid_reg <= 1'b0;
      end else if (link.vec_oe && !rd_n_reg && !ack_n_reg) begin
         vector_reg       <= link.vec_data;
         vector_valid_reg <= 1'b1;
      end
   end

   // status seen by the cpu side
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_cycle_active <= 1'b0;
      end else begin
         ack_cycle_active <= in_ack;
      end
   end

   assign link.peripheral_irq_ack_n = ack_n_reg;
   assign link.periph_rd_n          = rd_n_reg;
   assign link.periph_wr_n          = wr_n_reg;
   assign link.legacy_io_request_n  = legacy_ioreq_n_reg;
   assign cpu_wait_n                = wait_n_reg;
   assign cpu_vector                = vector_reg;
   assign cpu_vector_valid          = vector_valid_reg;

endmodule

`default_nettype wire

// ---- hw/ia_vectored_periph.sv ----
/*
   vectored peripheral end: claims the acknowledge, drives its vector on read.
   assumes the glue end drives the link on the same clk.
*/
`timescale 1ns/100ps
`default_nettype none

`include "ia_defs.svh"

module ia_vectored_periph
   import ia_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b0,
   parameter bit VECTORED   = 1'b1
)(
   input  wire logic    clk,
   input  wire logic    rst,
   input  wire logic    irq_request,
   input  wire vector_t vector_value,
   input  wire logic    chain_enable_in,
   output var  logic    irq_pending,
   output var  logic    ack_served,
   output var  logic    periph_reset,
   ia_link_if.periph    link
);

   localparam int unsigned VEC_NS  = FAST_GRADE ? `IA_VECTOR_VALID_FAST_NS
                                                : `IA_VECTOR_VALID_SLOW_NS;
   localparam int unsigned VEC_DLY = cycles_max(VEC_NS, `IA_CLK_PERIOD_NS);
   localparam int unsigned CW      = $clog2(VEC_DLY + 1);
   // state change and registered enable cost a cycle each, so the count stops two short
   localparam logic [CW-1:0] CNT_LAST = CW'((VEC_DLY > 1) ? VEC_DLY - 2 : 0);

   per_state_e    state_reg;
   logic [CW-1:0] cnt_reg;
   logic          pending_reg;
   logic          chain_out_reg;
   logic          oe_reg;
   vector_t       data_reg;
   logic          served_reg;
   logic          reset_seen_reg;
   logic          ack_act;
   logic          rd_act;
   logic          both_low;
   logic          done;

   assign ack_act  = ~link.peripheral_irq_ack_n & VECTORED;
   assign rd_act   = ~link.periph_rd_n;
   assign both_low = rd_act & ~link.periph_wr_n;
   assign done     = (state_reg == PER_DRIVE) & (~rd_act | ~ack_act);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= PER_IDLE;
         cnt_reg   <= '0;
      end else if (both_low) begin
         state_reg <= PER_IDLE;
         cnt_reg   <= '0;
      end else begin
         case (state_reg)
            PER_IDLE: begin
               cnt_reg <= '0;
               if (ack_act && chain_enable_in && pending_reg) begin
                  state_reg <= PER_SETTLE;
               end
            end
            PER_SETTLE: begin
               if (!ack_act) begin
                  state_reg <= PER_IDLE;
               end else if (rd_act) begin
                  if (cnt_reg == CNT_LAST) begin
                     state_reg <= PER_DRIVE;
                  end else begin
                     cnt_reg <= cnt_reg + CW'(1);
                  end
               end
            end
            PER_DRIVE: begin
               if (done) begin
                  state_reg <= PER_IDLE;
               end
            end
            default: state_reg <= PER_IDLE;
         endcase
      end
   end

   // request set wins over the service clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= irq_request | (pending_reg & ~done & ~both_low);
      end
   end

   // claimed acknowledge blocks the chain below this device
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chain_out_reg <= 1'b1;
      end else begin
         chain_out_reg <= chain_enable_in & ~(ack_act & pending_reg)
                          & (state_reg == PER_IDLE);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oe_reg         <= 1'b0;
         data_reg       <= `IA_VECTOR_RESET;
         served_reg     <= 1'b0;
         reset_seen_reg <= 1'b0;
      end else begin
         oe_reg         <= (state_reg == PER_DRIVE) & ~done;
         data_reg       <= vector_value;
         served_reg     <= done;
         reset_seen_reg <= both_low;
      end
   end

   assign link.vec_oe           = oe_reg;
   assign link.vec_data         = data_reg;
   assign link.chain_enable_out = chain_out_reg;
   assign irq_pending           = pending_reg;
   assign ack_served            = served_reg;
   assign periph_reset          = reset_seen_reg;

endmodule

`default_nettype wire

// ---- shared/ia_defs.svh ----
/*
   timing figures and reset values for the interrupt acknowledge glue.
   assumes a single 40 MHz system clock shared by both ends.
*/
`ifndef IA_DEFS_SVH
`define IA_DEFS_SVH

`define IA_CLK_PERIOD_NS        25
`define IA_ACK_TO_READ_SLOW_NS  350
`define IA_ACK_TO_READ_FAST_NS  250
`define IA_VECTOR_VALID_SLOW_NS 250
`define IA_VECTOR_VALID_FAST_NS 180
`define IA_EXTRA_WAIT_CYCLES    0
`define IA_STAGE_MARGIN_CYCLES  2
`define IA_VECTOR_RESET         8'h00

`endif

// ---- shared/ia_link_if.sv ----
/*
   peripheral-side acknowledge link between the glue logic and a vectored peripheral.
   assumes both ends run on the same clk; the bench joins the two modports.
*/
`timescale 1ns/100ps
`default_nettype none

interface ia_link_if;
   import ia_pkg::*;

   logic    peripheral_irq_ack_n;
   logic    periph_rd_n;
   logic    periph_wr_n;
   logic    legacy_io_request_n;
   vector_t vec_data;
   logic    vec_oe;
   logic    chain_enable_out;

   modport glue (
      output peripheral_irq_ack_n,
      output periph_rd_n,
      output periph_wr_n,
      output legacy_io_request_n,
      input  vec_data,
      input  vec_oe,
      input  chain_enable_out
   );

   modport periph (
      input  peripheral_irq_ack_n,
      input  periph_rd_n,
      input  periph_wr_n,
      input  legacy_io_request_n,
      output vec_data,
      output vec_oe,
      output chain_enable_out
   );

endinterface

`default_nettype wire

// ---- shared/ia_pkg.sv ----
/*
   types and cycle arithmetic shared by both ends of the acknowledge link.
   assumes ia_defs.svh supplies the figures.
*/
package ia_pkg;

   typedef logic [7:0] vector_t;

   typedef enum {PER_IDLE, PER_SETTLE, PER_DRIVE} per_state_e;

   // least time: round up, never below one cycle
   function automatic int unsigned cycles_min(input int unsigned ns, input int unsigned per);
      int unsigned c;
      c = (ns + per - 1) / per;
      return (c < 1) ? 1 : c;
   endfunction

   // longest time: round down, never below one cycle
   function automatic int unsigned cycles_max(input int unsigned ns, input int unsigned per);
      int unsigned c;
      c = ns / per;
      return (c < 1) ? 1 : c;
   endfunction

endpackage

// ---- verif/ia_link_monitor.sv ----
/*
   checker for the acknowledge link between glue and vectored peripheral.
   assumes slow grade, same clock, no extra wait; the bench keeps sys_rd_n high in ack.
*/
`timescale 1ns/100ps
`default_nettype none

module ia_link_monitor
   import ia_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst,
   input  wire logic    peripheral_irq_ack_n,
   input  wire logic    periph_rd_n,
   input  wire logic    periph_wr_n,
   input  wire logic    legacy_io_request_n,
   input  wire vector_t vec_data,
   input  wire logic    vec_oe,
   input  wire logic    chain_enable_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic [5:0] rd_low_reg;

   // saturates so a stuck read cannot wrap back into range
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rd_low_reg <= '0;
      else if (!periph_rd_n && !peripheral_irq_ack_n)
         rd_low_reg <= (rd_low_reg == 6'h3f) ? rd_low_reg : rd_low_reg + 6'h01;
      else
         rd_low_reg <= '0;
   end

   property p_reset_rw;
      $fell(rst) |-> !$past(periph_rd_n) && !$past(periph_wr_n);
   endproperty
   property p_read_delay;
      $fell(peripheral_irq_ack_n) |-> (periph_rd_n && !peripheral_irq_ack_n)[*8]
         ##6 (periph_rd_n && !peripheral_irq_ack_n) ##1 !periph_rd_n;
   endproperty
   property p_ack_first;
      !peripheral_irq_ack_n && $fell(periph_rd_n) |->
         !$past(peripheral_irq_ack_n, 14) && $past(peripheral_irq_ack_n, 15);
   endproperty
   property p_io_with_read;
      !peripheral_irq_ack_n && $fell(legacy_io_request_n) |-> $fell(periph_rd_n);
   endproperty
   property p_vec_gate;
      vec_oe |-> !$past(periph_rd_n) && !$past(peripheral_irq_ack_n);
   endproperty
   property p_vec_time;
      $rose(vec_oe) |-> rd_low_reg inside {[1:10]};
   endproperty
   property p_chain_block;
      !peripheral_irq_ack_n && vec_oe |-> !chain_enable_out;
   endproperty
   property p_oe_release;
      $rose(peripheral_irq_ack_n) |-> ##[0:1] !vec_oe;
   endproperty
   property p_rd_end;
      $rose(peripheral_irq_ack_n) |-> periph_rd_n;
   endproperty
   property p_vec_stable;
      vec_oe && $past(vec_oe) |-> $stable(vec_data);
   endproperty

   a_reset_rw:     assert property (p_reset_rw)     else $error("rd/wr not low in reset");
   a_read_delay:   assert property (p_read_delay)   else $error("read delay wrong");
   a_ack_first:    assert property (p_ack_first)    else $error("read without ack lead");
   a_io_with_read: assert property (p_io_with_read) else $error("io not with read");
   a_vec_gate:     assert property (p_vec_gate)     else $error("vector without ack+rd");
   a_vec_time:     assert property (p_vec_time)     else $error("vector time wrong");
   a_oe_release:   assert property (p_oe_release)   else $error("vector held after ack");
   a_rd_end:       assert property (p_rd_end)       else $error("read held after ack");
   a_vec_stable:   assert property (p_vec_stable)   else $error("vector changed");
   a_chain_block:  assert property (p_chain_block)  else $error("chain not blocked");

   c_ack: cover property ($fell(peripheral_irq_ack_n));
   c_vec: cover property ($rose(vec_oe));
   c_io:  cover property ($fell(legacy_io_request_n));
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
/*
   bench joining glue and vectored peripheral through ia_link_if.
   assumes default parameters: slow grade, one clock, no extra wait.
*/
`timescale 1ns/100ps
`default_nettype none

module tb
   import ia_pkg::*;
();
   logic    clk = 0, rst = 1;
   logic    opcode_fetch_cycle_n = 1, memory_request_n = 1, io_request_n = 1;
   logic    sys_rd_n = 1, sys_wr_n = 1, sys_wait_n = 1;
   logic    irq_request = 0, chain_enable_in = 1;
   vector_t vector_value = 8'h5a;
   logic    cpu_wait_n, cpu_vector_valid, ack_cycle_active;
   logic    irq_pending, ack_served, periph_reset;
   vector_t cpu_vector;
   int      fails = 0, check_count = 0;

   always #12.5 clk = ~clk;

   ia_link_if lnk ();
   ia_glue u_ia_glue (.clk(clk), .rst(rst), .opcode_fetch_cycle_n(opcode_fetch_cycle_n),
      .memory_request_n(memory_request_n), .io_request_n(io_request_n), .sys_rd_n(sys_rd_n),
      .sys_wr_n(sys_wr_n), .sys_wait_n(sys_wait_n), .cpu_wait_n(cpu_wait_n),
      .cpu_vector(cpu_vector), .cpu_vector_valid(cpu_vector_valid),
      .ack_cycle_active(ack_cycle_active), .link(lnk));
   ia_vectored_periph u_ia_vectored_periph (.clk(clk), .rst(rst), .irq_request(irq_request),
      .vector_value(vector_value), .chain_enable_in(chain_enable_in),
      .irq_pending(irq_pending), .ack_served(ack_served), .periph_reset(periph_reset),
      .link(lnk));
   ia_link_monitor u_mon (.clk(clk), .rst(rst), .peripheral_irq_ack_n(lnk.peripheral_irq_ack_n),
      .periph_rd_n(lnk.periph_rd_n), .periph_wr_n(lnk.periph_wr_n),
      .legacy_io_request_n(lnk.legacy_io_request_n), .vec_data(lnk.vec_data),
      .vec_oe(lnk.vec_oe), .chain_enable_out(lnk.chain_enable_out));

   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task step;
      @(posedge clk);
      #1;
   endtask

   task results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task t_reset;
      repeat (8) step;
      chk("rd_rst", lnk.periph_rd_n, 0);
      chk("wr_rst", lnk.periph_wr_n, 0);
      rst = 0;
      step;
      chk("ack_idle", lnk.peripheral_irq_ack_n, 1);
      chk("wait_idle", cpu_wait_n, 1);
      chk("chain_rst", lnk.chain_enable_out, 1);
      $display("test reset done");
   endtask

   task t_plain;
      sys_rd_n = 0;
      io_request_n = 0;
      sys_wait_n = 0;
      step;
      step;
      chk("rd", lnk.periph_rd_n, 0);
      chk("wait", cpu_wait_n, 0);
      chk("io", lnk.legacy_io_request_n, 0);
      chk("ack_io", lnk.peripheral_irq_ack_n, 1);
      sys_wr_n = 0;
      step;
      step;
      chk("prst", periph_reset, 1);
      {sys_rd_n, sys_wr_n, io_request_n, sys_wait_n} = 4'hf;
      step;
      step;
      chk("rd_off", lnk.periph_rd_n, 1);
      chk("wait_off", cpu_wait_n, 1);
      $display("test plain io done");
   endtask

   task t_fetch;
      opcode_fetch_cycle_n = 0;
      memory_request_n = 0;
      repeat (6) step;
      chk("ack_fetch", lnk.peripheral_irq_ack_n, 1);
      chk("wait_fetch", cpu_wait_n, 1);
      chk("cyc_fetch", ack_cycle_active, 0);
      opcode_fetch_cycle_n = 1;
      memory_request_n = 1;
      step;
      $display("test fetch done");
   endtask

   // chain low: peripheral must stay off the bus, glue timing unchanged
   task t_ack(input logic chain);
      int   n;
      int   r;
      int   w;
      logic got;
      chain_enable_in = chain;
      irq_request = 1;
      step;
      irq_request = 0;
      chk("pend", irq_pending, 1);
      opcode_fetch_cycle_n = 0;
      io_request_n = 0;
      n = 0;
      while (lnk.peripheral_irq_ack_n !== 1'b0 && n < 9) begin
         step;
         n++;
      end
      chk("ack_lat", 8'(n), 1);
      chk("wait_on", cpu_wait_n, 0);
      r = 0;
      w = 0;
      got = 0;
      while (cpu_wait_n !== 1'b1 && w < 60) begin
         step;
         w++;
         if (lnk.periph_rd_n === 1'b0 && r == 0)
            r = w;
         if (cpu_vector_valid === 1'b1)
            got = 1;
      end
      if (n == 9 || w == 60) begin
         fails++;
         results;
      end
      chk("rd_lat", 8'(r), 14);
      chk("wait_lat", 8'(w), 27);
      chk("vec_seen", got, chain);
      chk("cyc_ack", ack_cycle_active, 1);
      chk("chain_out", lnk.chain_enable_out, 0);
      if (chain)
         chk("vec", cpu_vector, vector_value);
      chk("io_ack", lnk.legacy_io_request_n, 0);
      opcode_fetch_cycle_n = 1;
      io_request_n = 1;
      step;
      step;
      chk("ack_end", lnk.peripheral_irq_ack_n, 1);
      chk("rd_end", lnk.periph_rd_n, 1);
      chk("served", ack_served, chain);
      chk("pend_end", irq_pending, !chain);
      $display("test ack chain %0d done", chain);
   endtask

   initial begin
      t_reset;
      t_plain;
      t_fetch;
      t_ack(1'b0);
      t_ack(1'b1);
      vector_value = 8'ha5;
      t_ack(1'b1);
      results;
   end
endmodule

`default_nettype wire
